// >>> inc/meta_pkg.sv
package meta_pkg;
	localparam int WORD_COUNT = 6;
	localparam int IDX_W = 3;
	localparam logic [IDX_W-1:0] WORD_FIRST = 3'h0;
	localparam logic [IDX_W-1:0] WORD_LINE = 3'h1;
	localparam logic [IDX_W-1:0] WORD_STAMP = 3'h2;
	localparam logic [IDX_W-1:0] WORD_TMR_A = 3'h3;
	localparam logic [IDX_W-1:0] WORD_TMR_B = 3'h4;
	localparam logic [IDX_W-1:0] WORD_IDENT = 3'h5;
	localparam logic [IDX_W-1:0] WORD_LAST = 3'h5;

	localparam int GAIN_LSB = 48;
	localparam int GAIN_W = 16;
	localparam int IO_LSB = 40;
	localparam int IO_W = 8;
	localparam int FFC_LSB = 36;
	localparam int PRESET_LSB = 32;
	localparam int SET_W = 4;
	localparam int EXPO_LSB = 0;
	localparam int HALF_W = 32;
	localparam int HI_LSB = 32;
	localparam int LO_LSB = 0;
	localparam int TRIG_LSB = 32;
	localparam int TRIG_W = 24;
	localparam int CNT_B_ST_LSB = 25;
	localparam int CNT_A_ST_LSB = 22;
	localparam int TMR_B_ST_LSB = 19;
	localparam int TMR_A_ST_LSB = 16;
	localparam int ST_W = 3;
	localparam int LINE_POS_LSB = 0;
	localparam int LINE_POS_W = 16;

	// exposure input is already in counts of this many ns
	localparam int EXPOSURE_UNIT_NS = 10;

	localparam logic [ST_W-1:0] ST_IDLE = 3'h0;
	localparam logic [ST_W-1:0] ST_TRIG_WAIT = 3'h1;
	localparam logic [ST_W-1:0] ST_ACTIVE = 3'h2;
	localparam logic [ST_W-1:0] ST_COMPLETED = 3'h3;
	localparam logic [ST_W-1:0] ST_OVERFLOW = 3'h4;
	localparam logic [ST_W-1:0] ST_WAIT_DELAY = 3'h5;

	localparam logic [TRIG_W-1:0] TRIG_RESET = 24'h000000;
	localparam logic [LINE_POS_W-1:0] LINE_POS_RESET = 16'h0000;
	localparam logic [HALF_W-1:0] FRAME_RESET = 32'h00000000;
	localparam logic [IO_W-1:0] IO_RESET = 8'h00;

	typedef logic [63:0] metadata_word64_t;
	typedef struct packed {
		metadata_word64_t data;
		logic [IDX_W-1:0] index;
		logic last;
	} meta_beat_t;
	typedef enum logic [1:0] {PK_IDLE, PK_WRITE, PK_ADDR, PK_PUSH} packer_state_t;
endpackage

// >>> inc/meta_stream_if.sv
interface meta_stream_if;
	import meta_pkg::*;
	meta_beat_t beat;
	logic valid;
	logic ready;
	modport src(output beat, output valid, input ready);
	modport snk(input beat, input valid, output ready);
endinterface

// >>> core/meta_word_store.sv
module meta_word_store
	import meta_pkg::*;
(
	input logic sys_clk,
	input logic wrEn,
	input logic [IDX_W-1:0] wrAddr,
	input metadata_word64_t wrData,
	input logic [IDX_W-1:0] rdAddr,
	output metadata_word64_t rdData
);
	metadata_word64_t mem [WORD_COUNT];

	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end
endmodule

// >>> core/meta_skid_buffer.sv
module meta_skid_buffer
	import meta_pkg::*;
(
	input logic sys_clk,
	input logic reset,
	meta_stream_if.snk inPort,
	meta_stream_if.src outPort
);
	meta_beat_t outBeat, next_outBeat, skidBeat, next_skidBeat;
	logic outValid, next_outValid, skidValid, next_skidValid;

	assign inPort.ready = !skidValid;
	assign outPort.beat = outBeat;
	assign outPort.valid = outValid;

	always_comb begin
		next_outBeat = outBeat;
		next_outValid = outValid;
		next_skidBeat = skidBeat;
		next_skidValid = skidValid;
		if (outPort.ready || !outValid) begin
			if (skidValid) begin
				next_outBeat = skidBeat;
				next_outValid = 1'b1;
				next_skidValid = 1'b0;
			end else begin
				next_outBeat = inPort.beat;
				next_outValid = inPort.valid;
			end
		end else if (inPort.valid && !skidValid) begin
			// receiver stalled: park the word instead of dropping it
			next_skidBeat = inPort.beat;
			next_skidValid = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			outBeat <= '0;
			outValid <= 1'b0;
			skidBeat <= '0;
			skidValid <= 1'b0;
		end else begin
			outBeat <= next_outBeat;
			outValid <= next_outValid;
			skidBeat <= next_skidBeat;
			skidValid <= next_skidValid;
		end
	end
endmodule

// >>> core/line_scan_frame_metadata_packer.sv
// What this block does
// - word one bits 63:48 carry the digital gain factor
// - word one bits 47:40 carry all I/O line states, first line lowest
// - word one bits 39:36 carry the active flat-field coefficient set index
// - word one bits 35:32 carry the active cycling preset index
// - word one bits 31:0 carry exposure time, one count per 10 ns
// - word two bits 55:32 count line triggers seen in this frame
// - word two bits 27:25 and 24:22 carry counter b and a state codes
// - word two bits 21:19 and 18:16 carry timer b and a state codes
// - word two bits 15:0 carry the line position within the frame
// - word three carries the whole 64-bit timestamp
// - word four: timer a value high half, counter a value low half
// - word five: timer b value high half, counter b value low half
// - word six bits 63:32 carry the settable device identifier
// - frame counter steps at each frame start, word six bits 31:0
module line_scan_frame_metadata_packer
	import meta_pkg::*;
(
	input logic sys_clk,
	input logic reset,
	input logic frameStart,
	input logic frameEnd,
	input logic lineTrigger,
	input logic lineCapture,
	input logic [GAIN_W-1:0] gainDigital,
	input logic [IO_W-1:0] ioLinePins,
	input logic [SET_W-1:0] flatFieldSet,
	input logic [SET_W-1:0] presetSet,
	input logic [HALF_W-1:0] exposureTime,
	input logic [ST_W-1:0] eventCounterAState,
	input logic [ST_W-1:0] eventCounterBState,
	input logic [ST_W-1:0] delayTimerAState,
	input logic [ST_W-1:0] delayTimerBState,
	input metadata_word64_t timestamp,
	input logic [HALF_W-1:0] delayTimerAValue,
	input logic [HALF_W-1:0] eventCounterAValue,
	input logic [HALF_W-1:0] delayTimerBValue,
	input logic [HALF_W-1:0] eventCounterBValue,
	input logic [HALF_W-1:0] deviceId,
	input logic metaReady,
	output logic metaValid,
	output metadata_word64_t metaData,
	output logic [IDX_W-1:0] metaIndex,
	output logic metaLast,
	output logic busy,
	output logic recordMissed
);
	meta_stream_if pushIf();
	meta_stream_if outIf();

	// I/O pins arrive from outside the clock domain: one chain per line
	wire logic [IO_W-1:0] ioStable;

	for (genvar ln = 0; ln < IO_W; ln++) begin : g_ioLine
		logic [2:0] chain, next_chain;
		logic level, next_level;

		always_comb begin
			next_chain = {chain[1:0], ioLinePins[ln]};
			// a line only moves once stages two and three agree
			next_level = (chain[1] == chain[2]) ? chain[2] : level;
		end

		always_ff @(posedge sys_clk or posedge reset) begin
			if (reset) begin
				chain <= {3{IO_RESET[ln]}};
				level <= IO_RESET[ln];
			end else begin
				chain <= next_chain;
				level <= next_level;
			end
		end

		assign ioStable[ln] = level;
	end

	// frame-owned counters
	logic [TRIG_W-1:0] trigCount, next_trigCount;
	logic [LINE_POS_W-1:0] linePos, next_linePos;
	logic [HALF_W-1:0] frameSequenceCount, next_frameSequenceCount;

	always_comb begin
		next_trigCount = trigCount;
		next_linePos = linePos;
		next_frameSequenceCount = frameSequenceCount;
		if (frameStart) begin
			next_trigCount = lineTrigger ? TRIG_W'(1) : TRIG_RESET;
			next_linePos = LINE_POS_RESET;
			next_frameSequenceCount = frameSequenceCount + 32'h1;
		end else begin
			if (lineTrigger) begin
				next_trigCount = trigCount + 24'h1;
			end
			if (lineCapture) begin
				next_linePos = linePos + 16'h1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			trigCount <= TRIG_RESET;
			linePos <= LINE_POS_RESET;
			frameSequenceCount <= FRAME_RESET;
		end else begin
			trigCount <= next_trigCount;
			linePos <= next_linePos;
			frameSequenceCount <= next_frameSequenceCount;
		end
	end

	// packer sequencer
	packer_state_t state, next_state;
	logic [IDX_W-1:0] wordIdx, next_wordIdx;
	logic recordStart;
	logic wrEn;
	metadata_word64_t wrData, rdData;

	// end of record, asked by both the writer and the pusher
	function automatic logic isLastWord(input logic [IDX_W-1:0] idx);
		return idx == WORD_LAST;
	endfunction

	// idle test shared by the frame end gate and the status flags
	function automatic logic isIdle(input packer_state_t s);
		return s == PK_IDLE;
	endfunction

	// word indices only ever step by one
	function automatic logic [IDX_W-1:0] stepWord(
		input logic [IDX_W-1:0] idx);
		return idx + 3'h1;
	endfunction

	// a frame end is only taken while no record is in flight
	assign recordStart = frameEnd && isIdle(state);

	always_comb begin
		next_state = state;
		next_wordIdx = wordIdx;
		wrEn = 1'b0;
		pushIf.valid = 1'b0;
		pushIf.beat = '0;
		case (state)
			PK_IDLE: begin
				if (recordStart) begin
					next_wordIdx = WORD_FIRST;
					next_state = PK_WRITE;
				end
			end
			PK_WRITE: begin
				wrEn = 1'b1;
				if (isLastWord(wordIdx)) begin
					next_wordIdx = WORD_FIRST;
					next_state = PK_ADDR;
				end else begin
					next_wordIdx = stepWord(wordIdx);
				end
			end
			PK_ADDR: begin
				// store read happens now; its data stand in the next cycle
				next_state = PK_PUSH;
			end
			PK_PUSH: begin
				pushIf.valid = 1'b1;
				pushIf.beat.data = rdData;
				pushIf.beat.index = wordIdx;
				pushIf.beat.last = isLastWord(wordIdx);
				if (pushIf.ready) begin
					if (isLastWord(wordIdx)) begin
						next_state = PK_IDLE;
					end else begin
						next_wordIdx = stepWord(wordIdx);
						next_state = PK_ADDR;
					end
				end
			end
			default: begin
				next_state = PK_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			state <= PK_IDLE;
			wordIdx <= WORD_FIRST;
		end else begin
			state <= next_state;
			wordIdx <= next_wordIdx;
		end
	end

	// frozen at frame end so a quick next frame start cannot clear them
	logic [TRIG_W-1:0] snapTrig, next_snapTrig;
	logic [LINE_POS_W-1:0] snapLinePos, next_snapLinePos;
	logic [HALF_W-1:0] snapFrame, next_snapFrame;

	always_comb begin
		next_snapTrig = snapTrig;
		next_snapLinePos = snapLinePos;
		next_snapFrame = snapFrame;
		if (recordStart) begin
			next_snapTrig = trigCount;
			next_snapLinePos = linePos;
			next_snapFrame = frameSequenceCount;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			snapTrig <= TRIG_RESET;
			snapLinePos <= LINE_POS_RESET;
			snapFrame <= FRAME_RESET;
		end else begin
			snapTrig <= next_snapTrig;
			snapLinePos <= next_snapLinePos;
			snapFrame <= next_snapFrame;
		end
	end

	// status ports are registered so they leave from flip-flops
	logic next_busy, next_recordMissed;

	always_comb begin
		next_busy = !isIdle(next_state);
		// one record in flight; a frame end meanwhile is reported, not queued
		next_recordMissed = frameEnd && !isIdle(state);
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			busy <= 1'b0;
			recordMissed <= 1'b0;
		end else begin
			busy <= next_busy;
			recordMissed <= next_recordMissed;
		end
	end

	// word assembly; live inputs are sampled on the cycle each word is stored
	always_comb begin
		wrData = '0;
		case (wordIdx)
			WORD_FIRST: begin
				wrData[GAIN_LSB +: GAIN_W] = gainDigital;
				wrData[IO_LSB +: IO_W] = ioStable;
				wrData[FFC_LSB +: SET_W] = flatFieldSet;
				wrData[PRESET_LSB +: SET_W] = presetSet;
				wrData[EXPO_LSB +: HALF_W] = exposureTime;
			end
			WORD_LINE: begin
				wrData[TRIG_LSB +: TRIG_W] = snapTrig;
				wrData[CNT_B_ST_LSB +: ST_W] = eventCounterBState;
				wrData[CNT_A_ST_LSB +: ST_W] = eventCounterAState;
				wrData[TMR_B_ST_LSB +: ST_W] = delayTimerBState;
				wrData[TMR_A_ST_LSB +: ST_W] = delayTimerAState;
				wrData[LINE_POS_LSB +: LINE_POS_W] = snapLinePos;
			end
			WORD_STAMP: begin
				wrData = timestamp;
			end
			WORD_TMR_A: begin
				wrData[HI_LSB +: HALF_W] = delayTimerAValue;
				wrData[LO_LSB +: HALF_W] = eventCounterAValue;
			end
			WORD_TMR_B: begin
				wrData[HI_LSB +: HALF_W] = delayTimerBValue;
				wrData[LO_LSB +: HALF_W] = eventCounterBValue;
			end
			WORD_IDENT: begin
				wrData[HI_LSB +: HALF_W] = deviceId;
				wrData[LO_LSB +: HALF_W] = snapFrame;
			end
			default: begin
				wrData = '0;
			end
		endcase
	end

	// one address serves both sides: all writes end before any read counts
	meta_word_store store (
		.sys_clk(sys_clk),
		.wrEn(wrEn),
		.wrAddr(wordIdx),
		.wrData(wrData),
		.rdAddr(wordIdx),
		.rdData(rdData)
	);

	// two entries, so a receiver stall never costs a word
	meta_skid_buffer buffer (
		.sys_clk(sys_clk),
		.reset(reset),
		.inPort(pushIf),
		.outPort(outIf)
	);

	assign outIf.ready = metaReady;
	// these all come from the buffer's output flip-flops
	assign metaValid = outIf.valid;
	assign metaData = outIf.beat.data;
	assign metaIndex = outIf.beat.index;
	assign metaLast = outIf.beat.last;
endmodule

// >>> bench/meta_packer_sva.sv
module meta_packer_sva
	import meta_pkg::*;
(
	input logic sys_clk,
	input logic reset,
	input logic frameEnd,
	input logic metaReady,
	input logic metaValid,
	input metadata_word64_t metaData,
	input logic [IDX_W-1:0] metaIndex,
	input logic metaLast,
	input logic busy,
	input logic recordMissed
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic [IDX_W-1:0] expIdx;
	logic [IDX_W-1:0] next_expIdx;
	logic take;
	assign take = metaValid && metaReady;
	always_comb begin
		next_expIdx = expIdx;
		if (take)
			next_expIdx = metaLast ? 3'h0 : expIdx + 3'h1;
	end
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			expIdx <= 3'h0;
		else
			expIdx <= next_expIdx;
	end
	a_stall_hold: assert property (
		metaValid && !metaReady |=> metaValid && $stable(metaData)
		&& $stable({metaIndex, metaLast})) else $error("stalled word moved");
	a_last_flag: assert property (
		metaValid |-> metaLast == (metaIndex == WORD_LAST))
		else $error("last flag wrong");
	a_spare_zero: assert property (
		metaValid && metaIndex == WORD_LINE |-> metaData[63:56] == 8'h00
		&& metaData[31:28] == 4'h0) else $error("spare bits set");
	a_index_order: assert property (
		metaValid |-> metaIndex == expIdx) else $error("word out of order");
	a_next_word: assert property (
		take && !metaLast |-> ##[1:3] metaValid) else $error("record gap");
	a_first_word: assert property (
		frameEnd && !busy && !metaValid |-> ##9 metaValid
		&& metaIndex == WORD_FIRST) else $error("first word late");
	a_busy_rise: assert property (
		frameEnd && !busy |=> busy) else $error("record not started");
	a_miss_pulse: assert property (
		frameEnd && busy |=> recordMissed) else $error("miss not flagged");
	a_miss_cause: assert property (
		recordMissed |-> $past(frameEnd) && $past(busy))
		else $error("spurious miss");
	c_record: cover property (take && metaLast);
	c_stall: cover property (metaValid && !metaReady);
	c_miss: cover property (recordMissed);
endmodule

bind line_scan_frame_metadata_packer meta_packer_sva i_meta_packer_sva (
	.sys_clk, .reset, .frameEnd, .metaReady, .metaValid, .metaData,
	.metaIndex, .metaLast, .busy, .recordMissed);

// >>> bench/meta_sink.sv
module meta_sink (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic stall,
	output logic metaReady
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pat;
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset)
			pat <= 4'h1;
		else
			pat <= {pat[2:0], pat[3] ^ pat[2]};
	end
	// sparse ready runs long enough to fill both buffer entries
	assign metaReady = !stall || (pat[3] && pat[0]);
endmodule

// >>> bench/line_scan_frame_metadata_packer_tb_top.sv
module line_scan_frame_metadata_packer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import meta_pkg::*;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic frameStart = 1'b0, frameEnd = 1'b0;
	logic lineTrigger = 1'b0, lineCapture = 1'b0, stall = 1'b0;
	logic [GAIN_W-1:0] gainDigital = 16'h0;
	logic [IO_W-1:0] ioLinePins = 8'h0;
	logic [SET_W-1:0] flatFieldSet = 4'h0, presetSet = 4'h0;
	logic [ST_W-1:0] eventCounterAState = 3'h0, eventCounterBState = 3'h0;
	logic [ST_W-1:0] delayTimerAState = 3'h0, delayTimerBState = 3'h0;
	logic [HALF_W-1:0] exposureTime = 32'h0, deviceId = 32'h0;
	logic [HALF_W-1:0] delayTimerAValue = 32'h0, eventCounterAValue = 32'h0;
	logic [HALF_W-1:0] delayTimerBValue = 32'h0, eventCounterBValue = 32'h0;
	metadata_word64_t timestamp = 64'h0;
	logic metaReady, metaValid, metaLast, busy, recordMissed;
	metadata_word64_t metaData;
	logic [IDX_W-1:0] metaIndex;
	meta_beat_t expQ[$];
	meta_beat_t e;
	int n_fail = 0;
	int checked = 0;
	logic [31:0] seed = 32'h4EF4;
	logic [HALF_W-1:0] frameCnt = 32'h0;
	logic [ST_W-1:0] tmrCode [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5};

	line_scan_frame_metadata_packer i_line_scan_frame_metadata_packer (
		.sys_clk, .reset, .frameStart, .frameEnd, .lineTrigger, .lineCapture,
		.gainDigital, .ioLinePins, .flatFieldSet, .presetSet, .exposureTime,
		.eventCounterAState, .eventCounterBState, .delayTimerAState,
		.delayTimerBState, .timestamp, .delayTimerAValue, .eventCounterAValue,
		.delayTimerBValue, .eventCounterBValue, .deviceId, .metaReady,
		.metaValid, .metaData, .metaIndex, .metaLast, .busy, .recordMissed);
	meta_sink i_meta_sink (.sys_clk, .reset, .stall, .metaReady);

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic end_sim();
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input meta_beat_t got, input meta_beat_t exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chkbit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// inputs held still per record: the design samples them live
	task automatic record(input int r);
		logic [31:0] v;
		int nCap = 0;
		int nTrig = 0;
		metadata_word64_t w [6];
		{gainDigital, ioLinePins, flatFieldSet, presetSet} = xs();
		exposureTime = xs();
		timestamp = {xs(), xs()};
		delayTimerAValue = xs();
		eventCounterAValue = xs();
		delayTimerBValue = xs();
		eventCounterBValue = xs();
		deviceId = xs();
		eventCounterAState = 3'(r % 6);
		eventCounterBState = 3'(5 - r % 6);
		delayTimerAState = tmrCode[r % 5];
		delayTimerBState = tmrCode[4 - r % 5];
		frameStart = 1'b1;
		lineTrigger = seed[3];
		nTrig = seed[3];
		frameCnt++;
		@(negedge sys_clk);
		frameStart = 1'b0;
		repeat (xs() % 9 + 1) begin
			v = xs();
			lineCapture = 1'b1;
			lineTrigger = v[0];
			nCap++;
			nTrig += v[0];
			@(negedge sys_clk);
		end
		lineCapture = 1'b0;
		lineTrigger = 1'b0;
		repeat (4) @(negedge sys_clk);
		w[0] = {gainDigital, ioLinePins, flatFieldSet, presetSet, exposureTime};
		w[1] = {8'h00, 24'(nTrig), 4'h0, eventCounterBState,
			eventCounterAState, delayTimerBState, delayTimerAState, 16'(nCap)};
		w[2] = timestamp;
		w[3] = {delayTimerAValue, eventCounterAValue};
		w[4] = {delayTimerBValue, eventCounterBValue};
		w[5] = {deviceId, frameCnt};
		for (int i = 0; i < 6; i++)
			expQ.push_back(meta_beat_t'{w[i], 3'(i), i == 5});
		frameEnd = 1'b1;
		@(negedge sys_clk);
		frameEnd = (r == 3);
		@(negedge sys_clk);
		frameEnd = 1'b0;
		chkbit(recordMissed, r == 3);
		chkbit(busy, 1'b1);
		repeat (300) if (expQ.size() != 0) @(negedge sys_clk);
		// the last word is only taken at the edge after its check
		@(negedge sys_clk);
	endtask

	initial begin
		forever #2 sys_clk = ~sys_clk;
	end

	// look between edges: a word seen here is taken at the coming edge
	always @(negedge sys_clk) begin
		if (!reset && metaValid === 1'b1 && metaReady === 1'b1) begin
			e = expQ.size() != 0 ? expQ.pop_front() : '1;
			case (e.index)
				WORD_FIRST: chk({metaData, metaIndex, metaLast}, e);
				WORD_LINE: chk({metaData, metaIndex, metaLast}, e);
				WORD_STAMP: chk({metaData, metaIndex, metaLast}, e);
				WORD_TMR_A: chk({metaData, metaIndex, metaLast}, e);
				WORD_TMR_B: chk({metaData, metaIndex, metaLast}, e);
				default: chk({metaData, metaIndex, metaLast}, e);
			endcase
		end
	end

	initial begin
		#100000;
		n_fail++;
		end_sim();
	end

	initial begin
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		reset = 1'b0;
		for (int r = 0; r < 8; r++) begin
			record(r);
			stall = ~stall;
		end
		chkbit(expQ.size() == 0, 1'b1);
		end_sim();
	end
endmodule
